/* tdcm_pkg.sv */
// Purpose: constants and types shared by the tolerant dual-channel monitor
// Assumes: 40 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   times are counted in 10 ms logic execution ticks, except the accept mode limit in seconds
package tdcm_pkg;
    // ========================================
    // clock and time base
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_TIME_NS   = 10_000_000;                     // one execution tick, 10 ms
    localparam int TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;   // 400000 clocks
    localparam int SEC_TIME_MS    = 1000;
    localparam int TICK_TIME_MS   = 10;
    localparam int TICKS_PER_SEC  = SEC_TIME_MS / TICK_TIME_MS;     // 100 ticks

    // ========================================
    // setting ranges (in ticks or seconds)
    localparam int DISC_MAX_TICKS = 6000;                           // 60 s
    localparam int HOLD_MAX_TICKS = 1000;                           // 10 s
    localparam int AND_MAX_SECS   = 60000;

    // ========================================
    // register map (byte addresses)
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_DISC     = 8'h04;
    localparam logic [7:0]  OFS_HOLD     = 8'h08;
    localparam logic [7:0]  OFS_ANDMAX   = 8'h0C;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;

    // control bit positions
    localparam int CTRL_COMPL    = 0;   // complementary input mode
    localparam int CTRL_AND_EN   = 1;   // dual channel with single-channel-accept
    localparam int CTRL_DON_EN   = 2;   // switch-on mismatch supervision
    localparam int CTRL_DOFF_EN  = 3;   // switch-off mismatch supervision
    localparam int CTRL_GATE_USE = 4;   // hold-off gate input in use
    localparam int CTRL_W        = 5;

    // status bit positions
    localparam int ST_GRANT = 0;
    localparam int ST_ERR_A = 1;
    localparam int ST_ERR_B = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_ANDM  = 4;
    localparam int ST_STATA = 5;
    localparam int ST_STATB = 6;
    localparam int ST_STATE = 8;        // three one-hot state bits

    // reset values
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [12:0] DISC_RST   = 13'h0000;
    localparam logic [9:0]  HOLD_RST   = 10'h000;
    localparam logic [15:0] ANDMAX_RST = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // monitor states, one-hot
    typedef enum logic [2:0] {
        ST_INACTIVE = 3'h1,
        ST_DISCREP  = 3'h2,
        ST_ACTIVE   = 3'h4
    } mon_state_t;
endpackage

/* tdcm_switch_model.sv */
// Purpose: dual-channel switch pair feeding the monitor pins
// Assumes: contact B wired normally closed when complementary
// Notes:   pins move just after a rising clock edge
`timescale 1ns/100ps
module tdcm_switch_model (
    input  wire logic aclk,   // bench clock
    input  wire logic on_a,   // contact A closed
    input  wire logic on_b,   // contact B closed
    input  wire logic compl,  // B contact inverted
    output logic      in_a,   // pin A
    output logic      in_b    // pin B
);
    // ========================================
    // contacts to pins, B inverted when complementary
    always_ff @(posedge aclk) begin
        in_a <= on_a;
        in_b <= compl ? ~on_b : on_b;
    end
endmodule

/* tolerant_dual_channel_monitor.sv */
// Purpose: lenient dual-channel evaluation of two switch/sensor inputs
// Assumes: inputs are asynchronous pins, settings written over AXI4-Lite
// Notes:   evaluation runs every clock, timers advance on the 10 ms tick
//
// Summary of operation
// - equivalent mode decodes inactive, discrepant, active
// - complementary mode inverts input B first
// - active needs both off since last active
// - one input cycling alone cannot restore active
// - inputs may reach off at different times
// - mismatch timeout flags the input not following
// - mismatch time zero unlimited, else 10 ms steps
// - separate supervision enables for on and off
// - fault when enabled supervision time has expired
// - errors clear on grant rise after both off
// - accept mode selects tolerant rules or plain AND
// - feedback falling edge with grant enters accept mode
// - feedback high or max time leaves accept mode
// - accept duration zero unlimited, else seconds
// - accept mode: one input cycle restores grant
// - no mismatch supervision during accept mode
// - hold-off masks brief switch-off, gate optional
// - hold-off delay 0 to 10 s, 10 ms steps
// - still off after hold-off drops grant
// - filtered states show waiting and hold-off
`timescale 1ns/100ps
module tolerant_dual_channel_monitor #(
    parameter int TICK_CYCLES = tdcm_pkg::TICK_CYCLES   // clocks per execution tick
) (
    input  wire logic        aclk,              // system clock, 40 MHz
    input  wire logic        aresetn,           // synchronous reset, active low
    input  wire logic        in_a,              // input A pin
    input  wire logic        in_b,              // input B pin
    input  wire logic        actuator_released, // actuator feedback pin
    input  wire logic        holdoff_gate,      // hold-off gate pin
    output logic             grant,             // release output
    output logic             err_a,             // mismatch timeout input A
    output logic             err_b,             // mismatch timeout input B
    output logic             fault,             // combined error
    output logic             stat_a,            // filtered state A
    output logic             stat_b,            // filtered state B
    output logic             accept_mode,       // single-channel-accept active
    input  wire logic [7:0]  awaddr,            // write address
    input  wire logic        awvalid,           // write address valid
    output logic             awready,           // write address ready
    input  wire logic [31:0] wdata,             // write data
    input  wire logic [3:0]  wstrb,             // write byte strobes
    input  wire logic        wvalid,            // write data valid
    output logic             wready,            // write data ready
    output logic [1:0]       bresp,             // write response
    output logic             bvalid,            // write response valid
    input  wire logic        bready,            // write response ready
    input  wire logic [7:0]  araddr,            // read address
    input  wire logic        arvalid,           // read address valid
    output logic             arready,           // read address ready
    output logic [31:0]      rdata,             // read data
    output logic [1:0]       rresp,             // read response
    output logic             rvalid,            // read data valid
    input  wire logic        rready             // read data ready
);

    // ========================================
    // state record
    typedef struct packed {
        logic [3:0]           s1;          // first sync stage
        logic [3:0]           s2;          // second sync stage
        logic                 act_prev;    // feedback one clock ago
        tdcm_pkg::mon_state_t state;
        logic                 and_mode;
        logic                 seen_a;      // A off since last active
        logic                 seen_b;      // B off since last active
        logic                 both_off;    // both off together
        logic                 dir_off;     // discrepancy on switching off
        logic                 err_a;
        logic                 err_b;
        logic                 stat_a;
        logic                 stat_b;
        logic [18:0]          tick_cnt;
        logic                 tick;
        logic [12:0]          dcnt;        // mismatch ticks
        logic [9:0]           hcnt;        // hold-off ticks
        logic [6:0]           sec_pre;     // ticks within a second
        logic [15:0]          and_secs;    // seconds in accept mode
        logic [4:0]           ctrl;
        logic [12:0]          disc_time;
        logic [9:0]           hold_time;
        logic [15:0]          and_max;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           wa;
        logic [31:0]          wd;
        logic [3:0]           ws;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } mon_t;

    mon_t r_r;
    mon_t r_nxt;
    logic raw_a;
    logic raw_b;
    logic hold_ok;
    logic masking;
    logic fa;
    logic fb;
    logic disc_exp;
    logic go_active;
    logic clr_err;
    logic set_a;
    logic set_b;
    logic act_fall;
    logic [31:0] merged;
    logic [31:0] status_w;

    // byte-lane merge of a write into a register word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ========================================
    // next-state logic
    always_comb begin
        r_nxt = r_r;
        // two-flop synchronisers for all pins
        r_nxt.s1 = {holdoff_gate, actuator_released, in_b, in_a};
        r_nxt.s2 = r_r.s1;
        r_nxt.act_prev = r_r.s2[2];

        // 10 ms execution tick
        r_nxt.tick = 1'b0;
        if (r_r.tick_cnt == 19'(TICK_CYCLES - 1)) begin
            r_nxt.tick_cnt = 19'h0_0000;
            r_nxt.tick = 1'b1;
        end else begin
            r_nxt.tick_cnt = r_r.tick_cnt + 19'h0_0001;
        end

        // on/off decode, B inverted when complementary
        raw_a = r_r.s2[0];
        raw_b = r_r.ctrl[tdcm_pkg::CTRL_COMPL] ? ~r_r.s2[1] : r_r.s2[1];

        // hold-off applies while active and gate permits
        hold_ok = (r_r.hold_time != 10'h000) && (r_r.state == tdcm_pkg::ST_ACTIVE) &&
                  (!r_r.ctrl[tdcm_pkg::CTRL_GATE_USE] || r_r.s2[3]);
        if (!hold_ok || (raw_a && raw_b)) begin
            r_nxt.hcnt = 10'h000;
        end else if (r_r.tick && (r_r.hcnt < r_r.hold_time)) begin
            r_nxt.hcnt = r_r.hcnt + 10'h001;
        end
        // mask ends at expiry, gate low means no mask when the gate is in use
        masking = hold_ok && (r_r.hcnt < r_r.hold_time);
        fa = raw_a || masking;
        fb = raw_b || masking;

        disc_exp = (r_r.disc_time != 13'h0000) && (r_r.dcnt >= r_r.disc_time) &&
                   (r_r.state == tdcm_pkg::ST_DISCREP) && !r_r.and_mode;

        go_active = 1'b0;
        if (fa && fb) begin
            if (r_r.state == tdcm_pkg::ST_ACTIVE) begin
                r_nxt.state = tdcm_pkg::ST_ACTIVE;
            end else if (r_r.and_mode || (r_r.seen_a && r_r.seen_b &&
                         !(r_r.ctrl[tdcm_pkg::CTRL_DON_EN] && disc_exp && !r_r.dir_off))) begin
                r_nxt.state = tdcm_pkg::ST_ACTIVE;
                go_active = 1'b1;
            end else begin
                r_nxt.state = tdcm_pkg::ST_DISCREP;
            end
        end else if (!fa && !fb) begin
            r_nxt.state = tdcm_pkg::ST_INACTIVE;
        end else begin
            r_nxt.state = tdcm_pkg::ST_DISCREP;
        end

        // off seen per input, no need for overlap
        r_nxt.seen_a = (r_r.seen_a || !fa) && !go_active;
        r_nxt.seen_b = (r_r.seen_b || !fb) && !go_active;
        r_nxt.both_off = (r_r.both_off || (!fa && !fb)) && !go_active;

        // direction of the current discrepancy
        case (r_r.state)
            tdcm_pkg::ST_ACTIVE: begin
                r_nxt.dir_off = (r_nxt.state == tdcm_pkg::ST_DISCREP);
            end
            tdcm_pkg::ST_DISCREP: begin
                r_nxt.dir_off = r_r.dir_off && (r_nxt.state == tdcm_pkg::ST_DISCREP);
            end
            default: begin
                r_nxt.dir_off = 1'b0;
            end
        endcase

        // mismatch counter idles in accept mode
        if ((r_nxt.state != tdcm_pkg::ST_DISCREP) || r_r.and_mode) begin
            r_nxt.dcnt = 13'h0000;
        end else if (r_r.tick && (r_r.dcnt != 13'h1FFF)) begin
            r_nxt.dcnt = r_r.dcnt + 13'h0001;
        end

        // flag the input that failed to follow
        set_a = disc_exp && (r_r.dir_off ? (r_r.ctrl[tdcm_pkg::CTRL_DOFF_EN] && fa)
                                         : (r_r.ctrl[tdcm_pkg::CTRL_DON_EN] && !fa));
        set_b = disc_exp && (r_r.dir_off ? (r_r.ctrl[tdcm_pkg::CTRL_DOFF_EN] && fb)
                                         : (r_r.ctrl[tdcm_pkg::CTRL_DON_EN] && !fb));
        // clear only on grant rise after both off; set wins
        clr_err = go_active && r_r.both_off;
        r_nxt.err_a = (r_r.err_a && !clr_err) || set_a;
        r_nxt.err_b = (r_r.err_b && !clr_err) || set_b;

        act_fall = r_r.act_prev && !r_r.s2[2];
        if (!r_r.ctrl[tdcm_pkg::CTRL_AND_EN]) begin
            r_nxt.and_mode = 1'b0;
        end else if (r_r.and_mode) begin
            r_nxt.and_mode = !(r_r.s2[2] ||
                             ((r_r.and_max != 16'h0000) && (r_r.and_secs >= r_r.and_max)));
        end else begin
            r_nxt.and_mode = act_fall && (r_r.state == tdcm_pkg::ST_ACTIVE);
        end
        // seconds timer for the accept mode limit
        if (!r_r.and_mode) begin
            r_nxt.sec_pre = 7'h00;
            r_nxt.and_secs = 16'h0000;
        end else if (r_r.tick) begin
            if (r_r.sec_pre == 7'(tdcm_pkg::TICKS_PER_SEC - 1)) begin
                r_nxt.sec_pre = 7'h00;
                if (r_r.and_secs != 16'hFFFF) begin
                    r_nxt.and_secs = r_r.and_secs + 16'h0001;
                end
            end else begin
                r_nxt.sec_pre = r_r.sec_pre + 7'h01;
            end
        end

        // filtered states: off while waiting for the other
        r_nxt.stat_a = fa && !((r_nxt.state != tdcm_pkg::ST_ACTIVE) && !r_r.and_mode && !r_nxt.seen_b);
        r_nxt.stat_b = fb && !((r_nxt.state != tdcm_pkg::ST_ACTIVE) && !r_r.and_mode && !r_nxt.seen_a);

        // AXI write channel capture
        if (awvalid && awready) begin
            r_nxt.aw_got = 1'b1;
            r_nxt.wa = awaddr;
        end
        if (wvalid && wready) begin
            r_nxt.w_got = 1'b1;
            r_nxt.wd = wdata;
            r_nxt.ws = wstrb;
        end
        merged = 32'h0000_0000;
        if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
            r_nxt.aw_got = 1'b0;
            r_nxt.w_got = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = tdcm_pkg::RESP_OKAY;
            case (r_r.wa)
                tdcm_pkg::OFS_CTRL: begin
                    merged = merge_bytes({27'h000_0000, r_r.ctrl}, r_r.wd, r_r.ws);
                    r_nxt.ctrl = merged[4:0];
                end
                tdcm_pkg::OFS_DISC: begin
                    merged = merge_bytes({19'h0_0000, r_r.disc_time}, r_r.wd, r_r.ws);
                    r_nxt.disc_time = merged[12:0];
                end
                tdcm_pkg::OFS_HOLD: begin
                    merged = merge_bytes({22'h00_0000, r_r.hold_time}, r_r.wd, r_r.ws);
                    r_nxt.hold_time = merged[9:0];
                end
                tdcm_pkg::OFS_ANDMAX: begin
                    merged = merge_bytes({16'h0000, r_r.and_max}, r_r.wd, r_r.ws);
                    r_nxt.and_max = merged[15:0];
                end
                tdcm_pkg::OFS_STATUS: begin
                    merged = 32'h0000_0000;
                end
                default: begin
                    r_nxt.bresp = tdcm_pkg::RESP_DECERR;
                end
            endcase
        end else if (r_r.bvalid && bready) begin
            r_nxt.bvalid = 1'b0;
        end

        // AXI read channel
        status_w = 32'h0000_0000;
        status_w[tdcm_pkg::ST_GRANT] = (r_r.state == tdcm_pkg::ST_ACTIVE);
        status_w[tdcm_pkg::ST_ERR_A] = r_r.err_a;
        status_w[tdcm_pkg::ST_ERR_B] = r_r.err_b;
        status_w[tdcm_pkg::ST_FAULT] = r_r.err_a || r_r.err_b;
        status_w[tdcm_pkg::ST_ANDM] = r_r.and_mode;
        status_w[tdcm_pkg::ST_STATA] = r_r.stat_a;
        status_w[tdcm_pkg::ST_STATB] = r_r.stat_b;
        status_w[tdcm_pkg::ST_STATE +: 3] = r_r.state;
        if (arvalid && arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp = tdcm_pkg::RESP_OKAY;
            case (araddr)
                tdcm_pkg::OFS_CTRL:   r_nxt.rdata = {27'h000_0000, r_r.ctrl};
                tdcm_pkg::OFS_DISC:   r_nxt.rdata = {19'h0_0000, r_r.disc_time};
                tdcm_pkg::OFS_HOLD:   r_nxt.rdata = {22'h00_0000, r_r.hold_time};
                tdcm_pkg::OFS_ANDMAX: r_nxt.rdata = {16'h0000, r_r.and_max};
                tdcm_pkg::OFS_STATUS: r_nxt.rdata = status_w;
                default: begin
                    r_nxt.rdata = 32'h0000_0000;
                    r_nxt.rresp = tdcm_pkg::RESP_DECERR;
                end
            endcase
        end else if (r_r.rvalid && rready) begin
            r_nxt.rvalid = 1'b0;
        end
    end

    // ========================================
    // state register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r <= '0;
            r_r.state <= tdcm_pkg::ST_INACTIVE;
            r_r.ctrl <= tdcm_pkg::CTRL_RST;
            r_r.disc_time <= tdcm_pkg::DISC_RST;
            r_r.hold_time <= tdcm_pkg::HOLD_RST;
            r_r.and_max <= tdcm_pkg::ANDMAX_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ========================================
    // outputs
    // grant follows the active state
    assign grant       = (r_r.state == tdcm_pkg::ST_ACTIVE);
    assign err_a       = r_r.err_a;
    assign err_b       = r_r.err_b;
    assign fault       = r_r.err_a || r_r.err_b;
    assign stat_a      = r_r.stat_a;
    assign stat_b      = r_r.stat_b;
    assign accept_mode = r_r.and_mode;
    assign awready     = !r_r.aw_got && !r_r.bvalid;
    assign wready      = !r_r.w_got && !r_r.bvalid;
    assign bvalid      = r_r.bvalid;
    assign bresp       = r_r.bresp;
    assign arready     = !r_r.rvalid;
    assign rvalid      = r_r.rvalid;
    assign rdata       = r_r.rdata;
    assign rresp       = r_r.rresp;

    // ========================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_both_off_inactive: assert property ((!fa && !fb) |=> !grant && r_r.state == tdcm_pkg::ST_INACTIVE)
        else $error("both inputs off did not give inactive");
    a_compl_invert: assert property ((r_r.ctrl[tdcm_pkg::CTRL_COMPL] && r_r.s2[1]) |-> !raw_b)
        else $error("complementary B high not treated as off");
    a_entry_sequence: assert property ($rose(grant) && !$past(r_r.and_mode) |-> $past(r_r.seen_a) && $past(r_r.seen_b))
        else $error("active entered without both inputs off");
    a_single_cycle: assert property ((r_r.state == tdcm_pkg::ST_DISCREP && !r_r.and_mode && !r_r.seen_b) |=> !$rose(grant))
        else $error("active regained with one input cycled");
    a_err_cause: assert property ($rose(r_r.err_a) |-> $past(r_r.state == tdcm_pkg::ST_DISCREP) && $past(disc_exp))
        else $error("mismatch flag without expired discrepancy");
    a_fault_enable: assert property ($rose(fault) |-> $past(r_r.ctrl[tdcm_pkg::CTRL_DON_EN] || r_r.ctrl[tdcm_pkg::CTRL_DOFF_EN]))
        else $error("fault raised with supervision disabled");
    a_err_clear: assert property ($fell(err_a) || $fell(err_b) |-> $rose(grant) && $past(r_r.both_off))
        else $error("errors cleared without valid activation");
    a_accept_entry: assert property ((r_r.ctrl[tdcm_pkg::CTRL_AND_EN] && act_fall && grant && !r_r.and_mode) |=> accept_mode)
        else $error("accept mode not entered on feedback fall");
    a_accept_exit: assert property ((r_r.and_mode && r_r.s2[2] && r_r.s1[2]) |=> !accept_mode ##1 !accept_mode)
        else $error("accept mode kept with feedback high");
    a_no_supervise: assert property (r_r.and_mode |=> r_r.dcnt == 13'h0000)
        else $error("mismatch counted in accept mode");
    a_holdoff_grant: assert property ((grant && masking) |=> grant)
        else $error("grant dropped during hold-off");

    c_activate: cover property ($rose(grant));
    c_accept: cover property ($rose(accept_mode) ##[1:20] $rose(grant));
    c_error_clear: cover property ($rose(err_a) ##[1:1000] $fell(err_a));
    c_holdoff: cover property (grant && masking && !raw_a);

endmodule

/* tolerant_dual_channel_monitor_tb.sv */
// Purpose: self-checking bench for the tolerant dual-channel monitor
// Assumes: execution tick shortened to 10 clocks
// Notes:   settings written and status read over AXI4-Lite
`timescale 1ns/100ps
module tolerant_dual_channel_monitor_tb;
    localparam int TK = 10;  // clocks per tick
    logic aclk = 0, aresetn = 0, on_a = 0, on_b = 0, compl = 0;
    logic actuator_released = 1, holdoff_gate = 0, in_a, in_b;
    logic grant, err_a, err_b, fault, stat_a, stat_b, accept_mode;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int error_cnt = 0, checks = 0;

    // ========================================
    // clock, design and switch pair
    always #12.5 aclk = ~aclk;
    tolerant_dual_channel_monitor #(.TICK_CYCLES(TK)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .in_a(in_a), .in_b(in_b),
        .actuator_released(actuator_released), .holdoff_gate(holdoff_gate), .grant(grant),
        .err_a(err_a), .err_b(err_b), .fault(fault), .stat_a(stat_a), .stat_b(stat_b),
        .accept_mode(accept_mode), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    tdcm_switch_model u_sw (
        .aclk(aclk), .on_a(on_a), .on_b(on_b), .compl(compl), .in_a(in_a), .in_b(in_b));

    // ========================================
    // verdict, compare and bus tasks
    task automatic finish_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stuck;
        error_cnt++;
        $display("unexpected at %0t: bus answer missing", $time);
        finish_test();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        if (n == 40) stuck();
        chk(bresp, er);
        // let an edge pass so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rd_st;
        int n;
        araddr <= tdcm_pkg::OFS_STATUS;
        arvalid <= 1;
        rready <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        rd = rdata;
        if (n == 40) stuck();
        chk(rresp, tdcm_pkg::RESP_OKAY);
        @(posedge aclk);
    endtask

    // ========================================
    // main sequence
    initial begin
        cyc(12);
        aresetn <= 1;
        cyc(2);
        chk({grant, err_a, err_b, fault, accept_mode}, 0);
        rd_st();
        chk(rd, 32'h0000_0100);
        wr(8'h20, 32'h0000_0001, tdcm_pkg::RESP_DECERR);
        wr(tdcm_pkg::OFS_CTRL, 32'h0000_000C, tdcm_pkg::RESP_OKAY);
        on_a <= 1;
        on_b <= 1;
        cyc(6);
        chk(grant, 1);
        on_a <= 0;
        cyc(6);
        chk(grant, 0);
        on_a <= 1;
        cyc(6);
        chk(grant, 0);
        chk({stat_a, stat_b}, 2'b01);
        on_b <= 0;
        cyc(6);
        on_b <= 1;
        cyc(6);
        chk({grant, fault}, 2'b10);
        wr(tdcm_pkg::OFS_DISC, 32'h0000_0003, tdcm_pkg::RESP_OKAY);
        on_a <= 0;
        cyc(6 * TK);
        chk({err_a, err_b, fault}, 3'b011);
        rd_st();
        chk(rd, 32'h0000_024C);
        on_b <= 0;
        cyc(6);
        on_a <= 1;
        on_b <= 1;
        cyc(6);
        chk({grant, err_b, fault}, 3'b100);
        on_a <= 0;
        on_b <= 0;
        wr(tdcm_pkg::OFS_CTRL, 32'h0000_0001, tdcm_pkg::RESP_OKAY);
        compl <= 1;
        cyc(6);
        on_a <= 1;
        on_b <= 1;
        cyc(6);
        chk(grant, 1);
        on_b <= 0;
        cyc(6);
        chk(grant, 0);
        on_a <= 0;
        wr(tdcm_pkg::OFS_CTRL, 32'h0000_0002, tdcm_pkg::RESP_OKAY);
        compl <= 0;
        cyc(6);
        on_a <= 1;
        on_b <= 1;
        cyc(6);
        actuator_released <= 0;
        cyc(6);
        chk({grant, accept_mode}, 2'b11);
        on_a <= 0;
        cyc(6);
        chk(grant, 0);
        on_a <= 1;
        cyc(6);
        chk(grant, 1);
        actuator_released <= 1;
        cyc(6);
        chk(accept_mode, 0);
        wr(tdcm_pkg::OFS_ANDMAX, 32'h0000_0001, tdcm_pkg::RESP_OKAY);
        actuator_released <= 0;
        cyc(6);
        chk(accept_mode, 1);
        cyc(102 * TK);
        chk({accept_mode, fault}, 0);
        actuator_released <= 1;
        wr(tdcm_pkg::OFS_CTRL, 32'h0000_0010, tdcm_pkg::RESP_OKAY);
        wr(tdcm_pkg::OFS_HOLD, 32'h0000_0005, tdcm_pkg::RESP_OKAY);
        holdoff_gate <= 1;
        on_a <= 0;
        cyc(2 * TK);
        chk({grant, stat_a}, 2'b11);
        on_a <= 1;
        cyc(6);
        on_b <= 0;
        cyc(8 * TK);
        chk(grant, 0);
        on_a <= 0;
        cyc(6);
        on_a <= 1;
        on_b <= 1;
        holdoff_gate <= 0;
        cyc(6);
        on_a <= 0;
        cyc(6);
        chk(grant, 0);
        finish_test();
    end
endmodule
